/* logic/imb_master.sv */
// I2C master start, byte transmit and stop engine with its bit-rate counter.
// Assumes open-drain pads outside and software control bits on the clock domain.
// Function
// - Master operation only with master mode field and port enable set.
// - No queueing; buffer write during a pending operation dropped, write collision set.
// - Master makes all SCL pulses, START and STOP conditions.
// - Write transfer: address plus zero bit, 8-bit bytes, slave acknowledges each.
// - Read transfer: address plus one bit, slave sends bytes, master acknowledges; this block has no receive path and only transmits.
// - Counter reload value is low seven bits of the address reload register.
// - Counter counts down to zero, halts, reloads automatically in master operation.
// - Counter decrements on second and fourth phase of each instruction cycle.
// - During arbitration the counter reloads only once SCL is sampled high.
// - Buffer write starts the counter; after acknowledge it stops, SCL held.
// - Start request bit 0 begins a START if both lines are high.
// - First period expiring with lines high drives SDA low, sets start-detected.
// - One more period, then start request clears and counter halts, SDA low.
// - Lines low at start or SCL low early: bus collision, abort, idle.
// - Buffer write during START keeps buffer and sets write collision.
// - Low five control-two bits ignore writes until START completes.
// - START completion sets port event flag after the hold period.
// - Address byte shifted out, acknowledge captured in bit 6, event flag set.
// - Stop request bit 2 ends transfer; event raised once STOP completes.
// - Buffer full sets on buffer write, clears when eight bits are out.
// - Port event flag sets on START, STOP and each finished byte.
module imb_master
  import imb_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       link_clk,
  input  wire logic [3:0] port_mode_field,
  input  wire logic       port_enable_bit,
  input  wire logic [7:0] address_reload_register,
  input  wire logic       ctl2_wr,
  input  wire logic [7:0] ctl2_wdata,
  input  wire logic       buf_wr,
  input  wire logic [7:0] buf_wdata,
  input  wire logic       event_clr,
  input  wire logic       bcol_clr,
  input  wire logic       write_collision_flag_clr,
  input  wire logic       sda_i,
  input  wire logic       scl_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            scl_o,
  output logic            scl_oe,
  output logic [7:0]      control_two,
  output logic [7:0]      port_status_register,
  output logic [7:0]      transfer_buffer,
  output logic            port_event_flag,
  output logic            bus_collision_flag,
  output logic            write_collision_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Clock domain: control bits, flags and command issue.

  logic                en_r;
  logic                busy_r;
  logic                start_req_r;
  logic                stop_req_r;
  logic                ackstat_r;
  logic                ackdata_r;
  logic                gencall_r;
  logic                bf_r;
  logic                sdet_r;
  logic                evf_r;
  logic                bcol_r;
  logic                write_collision_flag_r;
  logic [7:0]          buf_r;
  logic [RELOAD_W-1:0] reload_hold_r;
  logic [CMD_N-1:0]    cmd_tgl_r;
  logic [EV_N-1:0]     ev_s;
  logic [EV_N-1:0]     ev_d_r;
  logic [EV_N-1:0]     ev;
  logic                take_ctl2;
  logic                go_start;
  logic                go_stop;
  logic                go_tx;
  logic                write_collision_flag_set;
  logic                done;
  logic                ack_l_r;

  assign ev        = ev_s ^ ev_d_r;
  assign take_ctl2 = ctl2_wr && en_r && !busy_r;
  assign go_start  = take_ctl2 && ctl2_wdata[C2_START];
  assign go_stop   = take_ctl2 && !ctl2_wdata[C2_START] && ctl2_wdata[C2_STOP];
  assign go_tx     = buf_wr && en_r && !busy_r && !go_start && !go_stop;
  assign write_collision_flag_set  = buf_wr && en_r && (busy_r || go_start || go_stop);
  assign done      = ev[EV_SDONE] || ev[EV_COLL] || ev[EV_BDONE] || ev[EV_PDONE];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= 1'b0;
    end else begin
      en_r <= port_enable_bit && (port_mode_field == MODE_MASTER);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ev_d_r <= '0;
    end else begin
      ev_d_r <= ev_s;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_r        <= 1'b0;
      cmd_tgl_r     <= '0;
      reload_hold_r <= '0;
    end else if (!en_r) begin
      busy_r <= 1'b0;
    end else if (go_start || go_stop || go_tx) begin
      busy_r                <= 1'b1;
      reload_hold_r         <= address_reload_register[RELOAD_W-1:0];
      cmd_tgl_r[CMD_START] <= cmd_tgl_r[CMD_START] ^ go_start;
      cmd_tgl_r[CMD_STOP]  <= cmd_tgl_r[CMD_STOP] ^ go_stop;
      cmd_tgl_r[CMD_TX]    <= cmd_tgl_r[CMD_TX] ^ go_tx;
    end else if (done) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      start_req_r <= 1'b0;
      stop_req_r  <= 1'b0;
    end else if (!en_r) begin
      start_req_r <= 1'b0;
      stop_req_r  <= 1'b0;
    end else begin
      if (go_start) begin
        start_req_r <= 1'b1;
      end else if (ev[EV_SDONE] || ev[EV_COLL]) begin
        start_req_r <= 1'b0;
      end
      if (go_stop) begin
        stop_req_r <= 1'b1;
      end else if (ev[EV_PDONE]) begin
        stop_req_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ackdata_r <= 1'b0;
      gencall_r <= 1'b0;
    end else if (ctl2_wr) begin
      ackdata_r <= ctl2_wdata[C2_ACKDATA];
      gencall_r <= ctl2_wdata[C2_GENCALL];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ackstat_r <= 1'b0;
    end else if (ev[EV_BDONE]) begin
      ackstat_r <= ack_l_r;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      buf_r <= BUF_RST;
      bf_r  <= 1'b0;
    end else if (go_tx) begin
      buf_r <= buf_wdata;
      bf_r  <= 1'b1;
    end else if (ev[EV_SENT8] || !en_r) begin
      bf_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sdet_r <= 1'b0;
    end else if (ev[EV_SEEN]) begin
      sdet_r <= 1'b1;
    end else if (ev[EV_PDONE] || !en_r) begin
      sdet_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evf_r  <= 1'b0;
      bcol_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
    end else begin
      evf_r  <= ev[EV_SDONE] || ev[EV_BDONE] || ev[EV_PDONE] || (evf_r && !event_clr);
      bcol_r <= ev[EV_COLL] || (bcol_r && !bcol_clr);
      write_collision_flag_r <= write_collision_flag_set || (write_collision_flag_r && !write_collision_flag_clr);
    end
  end

  assign control_two          = {gencall_r, ackstat_r, ackdata_r, 2'h0, stop_req_r, 1'b0, start_req_r};
  assign port_status_register = {4'h0, sdet_r, 2'h0, bf_r};
  assign transfer_buffer      = buf_r;
  assign port_event_flag      = evf_r;
  assign bus_collision_flag   = bcol_r;
  assign write_collision_flag = write_collision_flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: synchronisers (u_ev runs on clock), phase ticks and bit-rate counter.

  logic                lrst_b;
  logic [CMD_N:0]      cmd_s;
  logic [CMD_N-1:0]    cmd_d_r;
  logic [CMD_N-1:0]    cmd_ev;
  logic                en_s;
  logic [1:0]          pin_s;
  logic                sda_s;
  logic                scl_s;
  logic [EV_N-1:0]     ev_tgl_r;
  logic [1:0]          phase_r;
  logic                tick;
  logic [RELOAD_W-1:0] cnt_r;
  logic                expire;
  logic                ld;
  logic [EV_N-1:0]     ev_set;
  imb_state_t          st_r;
  imb_state_t          st_nxt;
  logic [3:0]          bit_r;
  logic [7:0]          shreg_r;
  logic                sda_low_r;
  logic                scl_low_r;

  imb_sync2 #(.W(1)) u_lrst (.clk(link_clk), .rst_b(rst_b), .d(1'b1), .q(lrst_b));
  imb_sync2 #(.W(CMD_N + 1)) u_cmd (.clk(link_clk), .rst_b(lrst_b), .d({en_r, cmd_tgl_r}), .q(cmd_s));
  imb_sync2 #(.W(2)) u_pin (.clk(link_clk), .rst_b(lrst_b), .d({sda_i, scl_i}), .q(pin_s));
  imb_sync2 #(.W(EV_N)) u_ev (.clk(clock), .rst_b(rst_b), .d(ev_tgl_r), .q(ev_s));

  assign en_s   = cmd_s[CMD_N];
  assign cmd_ev = cmd_s[CMD_N-1:0] ^ cmd_d_r;
  assign sda_s  = pin_s[1];
  assign scl_s  = pin_s[0];
  assign tick   = (phase_r == PH_SECOND) || (phase_r == PH_FOURTH);
  assign expire = (cnt_r == '0);

  always_ff @(posedge link_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      cmd_d_r  <= '0;
      ev_tgl_r <= '0;
      phase_r  <= 2'h0;
    end else begin
      cmd_d_r  <= cmd_s[CMD_N-1:0];
      ev_tgl_r <= ev_tgl_r ^ ev_set;
      phase_r  <= phase_r + 2'h1;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      cnt_r <= '0;
    end else if (ld) begin
      cnt_r <= reload_hold_r;
    end else if (tick && !expire) begin
      cnt_r <= cnt_r - 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: sequence control.

  always_comb begin
    st_nxt = st_r;
    ld     = 1'b0;
    ev_set = '0;
    if (!en_s) begin
      st_nxt = S_IDLE;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (cmd_ev[CMD_START]) begin
            if (sda_s && scl_s) begin
              ld     = 1'b1;
              st_nxt = S_ST_WAIT;
            end else begin
              ev_set[EV_COLL] = 1'b1;
            end
          end else if (cmd_ev[CMD_STOP]) begin
            ld     = 1'b1;
            st_nxt = S_SP_LOW;
          end else if (cmd_ev[CMD_TX]) begin
            ld     = 1'b1;
            st_nxt = S_TX_LOW;
          end
        end
        S_ST_WAIT: begin
          if (!scl_s || (expire && !sda_s)) begin
            ev_set[EV_COLL] = 1'b1;
            st_nxt          = S_IDLE;
          end else if (expire) begin
            ld              = 1'b1;
            ev_set[EV_SEEN] = 1'b1;
            st_nxt          = S_ST_HOLD;
          end
        end
        S_ST_HOLD: begin
          if (expire) begin
            ev_set[EV_SDONE] = 1'b1;
            st_nxt           = S_IDLE;
          end
        end
        S_TX_LOW: begin
          if (expire) begin
            st_nxt = S_TX_RISE;
          end
        end
        S_TX_RISE: begin
          if (scl_s) begin
            ld     = 1'b1;
            st_nxt = S_TX_HIGH;
          end
        end
        S_TX_HIGH: begin
          if (expire && bit_r == ACK_BIT) begin
            ev_set[EV_BDONE] = 1'b1;
            st_nxt           = S_IDLE;
          end else if (expire) begin
            ld               = 1'b1;
            ev_set[EV_SENT8] = (bit_r == LAST_BIT);
            st_nxt           = S_TX_LOW;
          end
        end
        S_SP_LOW: begin
          if (expire) begin
            st_nxt = S_SP_RISE;
          end
        end
        S_SP_RISE: begin
          if (scl_s) begin
            ld     = 1'b1;
            st_nxt = S_SP_HIGH;
          end
        end
        S_SP_HIGH: begin
          if (expire) begin
            ld     = 1'b1;
            st_nxt = S_SP_SETTLE;
          end
        end
        S_SP_SETTLE: begin
          if (expire) begin
            ev_set[EV_PDONE] = 1'b1;
            st_nxt           = S_IDLE;
          end
        end
        default: begin
          st_nxt = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      st_r <= S_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      bit_r   <= 4'h0;
      shreg_r <= 8'h00;
      ack_l_r <= 1'b0;
    end else if (st_r == S_IDLE && st_nxt == S_TX_LOW) begin
      bit_r   <= 4'h0;
      shreg_r <= buf_r;
    end else if (st_r == S_TX_HIGH && st_nxt == S_TX_LOW) begin
      bit_r   <= bit_r + 4'h1;
      shreg_r <= {shreg_r[6:0], 1'b0};
    end else if (st_r == S_TX_HIGH && st_nxt == S_IDLE) begin
      ack_l_r <= sda_s;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_b) begin
    if (!lrst_b) begin
      sda_low_r <= 1'b0;
      scl_low_r <= 1'b0;
    end else if (!en_s) begin
      sda_low_r <= 1'b0;
      scl_low_r <= 1'b0;
    end else if (st_r == S_TX_LOW) begin
      // Data moves one cycle after SCL has fallen, so it never changes while SCL is high.
      sda_low_r <= (bit_r == ACK_BIT) ? 1'b0 : !shreg_r[NBITS-1];
      scl_low_r <= (st_nxt == S_TX_LOW);
    end else if (st_nxt != st_r) begin
      case (st_nxt)
        S_ST_HOLD: sda_low_r <= 1'b1;
        S_TX_LOW:  scl_low_r <= 1'b1;
        S_TX_RISE, S_SP_RISE: scl_low_r <= 1'b0;
        S_SP_LOW: begin
          scl_low_r <= 1'b1;
          sda_low_r <= 1'b1;
        end
        S_SP_SETTLE: sda_low_r <= 1'b0;
        S_IDLE: begin
          if (st_r == S_TX_HIGH) begin
            scl_low_r <= 1'b1;
          end
        end
        default: begin
          sda_low_r <= sda_low_r;
        end
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign scl_o  = 1'b0;
  assign sda_oe = sda_low_r;
  assign scl_oe = scl_low_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_write_collision_flag;
    @(posedge clock) disable iff (!rst_b)
      (buf_wr && en_r && busy_r) |=> (write_collision_flag_r && $stable(buf_r));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("buffer write while busy not refused");

  property p_bf_set;
    @(posedge clock) disable iff (!rst_b)
      go_tx |=> (bf_r && busy_r && transfer_buffer == $past(buf_wdata));
  endproperty
  a_bf_set: assert property (p_bf_set) else $error("buffer write not taken");

  property p_ctl2_locked;
    @(posedge clock) disable iff (!rst_b)
      (ctl2_wr && start_req_r && !ev[EV_SDONE] && !ev[EV_COLL]) |=> (start_req_r && !stop_req_r);
  endproperty
  a_ctl2_locked: assert property (p_ctl2_locked) else $error("control write acted during start");

  property p_halt;
    @(posedge link_clk) disable iff (!lrst_b)
      (expire && !ld) |=> expire;
  endproperty
  a_halt: assert property (p_halt) else $error("counter left zero without reload");

  property p_dec;
    @(posedge link_clk) disable iff (!lrst_b)
      (!expire && !ld && !tick) ##1 (!ld && tick) |=> (cnt_r == $past(cnt_r, 2) - 7'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("counter step wrong on phase tick");

  property p_arb;
    @(posedge link_clk) disable iff (!lrst_b)
      (st_r == S_TX_RISE && en_s && !scl_s) |=> (st_r == S_TX_RISE && !scl_oe);
  endproperty
  a_arb: assert property (p_arb) else $error("high phase left while SCL held low");

  property p_start_sda;
    @(posedge link_clk) disable iff (!lrst_b)
      (st_r == S_ST_WAIT && en_s && expire && sda_s && scl_s) |=> (sda_oe && !scl_oe && st_r == S_ST_HOLD);
  endproperty
  a_start_sda: assert property (p_start_sda) else $error("start edge not driven");

  property p_coll;
    @(posedge link_clk) disable iff (!lrst_b)
      (st_r == S_ST_WAIT && en_s && !scl_s) |=> (st_r == S_IDLE && !sda_oe);
  endproperty
  a_coll: assert property (p_coll) else $error("start not aborted on collision");

  property p_release;
    @(posedge link_clk) disable iff (!lrst_b)
      !en_s |=> (!sda_oe && !scl_oe && st_r == S_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("lines held while not master");

  property p_stop_event;
    @(posedge clock) disable iff (!rst_b)
      ev[EV_PDONE] |=> (port_event_flag && !stop_req_r && !busy_r);
  endproperty
  a_stop_event: assert property (p_stop_event) else $error("stop completion not flagged");

endmodule

/* logic/imb_pkg.sv */
// Constants, field positions and state type of the master start and bit-rate block.
// Assumes it is compiled ahead of every file that imports it.
package imb_pkg;

  localparam logic [3:0] MODE_MASTER  = 4'h8;
  localparam int         RELOAD_W     = 7;
  localparam int         NBITS        = 8;
  localparam logic [3:0] LAST_BIT     = 4'h7;
  localparam logic [3:0] ACK_BIT      = 4'h8;
  localparam logic [1:0] PH_SECOND    = 2'h1;
  localparam logic [1:0] PH_FOURTH    = 2'h3;

  localparam int C2_START    = 0;
  localparam int C2_RESTART  = 1;
  localparam int C2_STOP     = 2;
  localparam int C2_ACKDATA  = 5;
  localparam int C2_ACKSTAT  = 6;
  localparam int C2_GENCALL  = 7;
  localparam int ST_START    = 3;
  localparam int ST_FULL     = 0;

  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 1;
  localparam int CMD_TX    = 2;
  localparam int CMD_N     = 3;

  localparam int EV_SEEN   = 0;
  localparam int EV_SDONE  = 1;
  localparam int EV_SENT8  = 2;
  localparam int EV_BDONE  = 3;
  localparam int EV_PDONE  = 4;
  localparam int EV_COLL   = 5;
  localparam int EV_N      = 6;

  localparam logic [7:0] BUF_RST = 8'h00;

  typedef enum logic [3:0] {
    S_IDLE, S_ST_WAIT, S_ST_HOLD, S_TX_LOW, S_TX_RISE, S_TX_HIGH,
    S_SP_LOW, S_SP_RISE, S_SP_HIGH, S_SP_SETTLE
  } imb_state_t;

endpackage

/* logic/imb_sync2.sv */
// Two-flop synchroniser for levels and toggles, one stage pair per bit.
// Assumes every bit of d is a level that is stable for at least two clk edges.
module imb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* tb/imb_slave.sv */
// Behavioural I2C slave on the open-drain bus, acknowledging only the first byte after START.
// Assumes scl and sda are resolved wire levels with pull-ups.
module imb_slave (
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  stretch,
  output logic       sda_oe,
  output logic       scl_oe,
  output logic [7:0] rx,
  output realtime    min_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  int      cnt;
  int      nb;
  realtime t_hi;
  initial begin
    sda_oe = 0;
    scl_oe = 0;
    rx = 8'h00;
    cnt = 0;
    nb = 0;
    t_hi = 0;
    min_hi = 1.0e9;
  end
  // A START clears the bit and byte counts.
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
      nb = 0;
    end
  end
  always @(posedge scl) begin
    if (cnt < 8) rx = {rx[6:0], sda};
    cnt = cnt + 1;
    t_hi = $realtime;
  end
  always @(negedge scl) begin
    if (t_hi > 0 && $realtime - t_hi < min_hi) min_hi = $realtime - t_hi;
    if (cnt == 8) sda_oe = (nb == 0);
    if (cnt == 9) begin
      sda_oe = 0;
      cnt = 0;
      nb = nb + 1;
    end
    // Holds SCL low to force clock arbitration.
    if (stretch && cnt == 3) begin
      scl_oe = 1;
      #200;
      scl_oe = 0;
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the master start, byte and stop engine.
// Assumes the behavioural slave and pull-ups on both lines.
module testbench
  import imb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 0;
  logic       link_clk = 0;
  logic       rst_b = 0;
  logic [3:0] mode = 4'h0;
  logic       en = 0;
  logic       ctl2_wr = 0;
  logic [7:0] ctl2_wdata = 8'h00;
  logic       buf_wr = 0;
  logic [7:0] buf_wdata = 8'h00;
  logic       event_clr = 0;
  logic       bcol_clr = 0;
  logic       write_collision_flag_clr = 0;
  logic [1:0] hold = 2'b00;
  logic       stretch = 0;
  logic       sda_o, sda_oe, scl_o, scl_oe, s_sda_oe, s_scl_oe;
  logic [7:0] control_two, port_status_register, transfer_buffer, rx;
  logic       port_event_flag, bus_collision_flag, write_collision_flag;
  realtime    min_hi;
  int         err_count = 0;
  int         n_checks = 0;
  int         cyc = 0;
  wire logic  sda = ~(sda_oe | s_sda_oe | hold[0]);
  wire logic  scl = ~(scl_oe | s_scl_oe | hold[1]);
  //////////////////////////////////////////////////////////////////////////////
  always #4 clock = ~clock;
  initial begin
    #1.3;
    forever #6 link_clk = ~link_clk;
  end
  imb_master dut (.clock(clock), .rst_b(rst_b), .link_clk(link_clk), .port_mode_field(mode),
    .port_enable_bit(en), .address_reload_register(8'h86), .ctl2_wr(ctl2_wr), .ctl2_wdata(ctl2_wdata),
    .buf_wr(buf_wr), .buf_wdata(buf_wdata), .event_clr(event_clr), .bcol_clr(bcol_clr),
    .write_collision_flag_clr(write_collision_flag_clr), .sda_i(sda), .scl_i(scl), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o),
    .scl_oe(scl_oe), .control_two(control_two), .port_status_register(port_status_register),
    .transfer_buffer(transfer_buffer), .port_event_flag(port_event_flag),
    .bus_collision_flag(bus_collision_flag), .write_collision_flag(write_collision_flag));
  imb_slave slave (.scl(scl), .sda(sda), .stretch(stretch), .sda_oe(s_sda_oe), .scl_oe(s_scl_oe),
    .rx(rx), .min_hi(min_hi));
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr2(input logic [7:0] v);
    @(posedge clock) ctl2_wr <= 1;
    ctl2_wdata <= v;
    @(posedge clock) ctl2_wr <= 0;
    #1;
  endtask
  task automatic wrb(input logic [7:0] v);
    @(posedge clock) buf_wr <= 1;
    buf_wdata <= v;
    @(posedge clock) buf_wr <= 0;
    #1;
  endtask
  task automatic wait_ev();
    for (int i = 0; i < 6000 && port_event_flag !== 1'b1; i++) @(posedge clock);
    chk("event", port_event_flag, 1);
    @(posedge clock) event_clr <= 1;
    @(posedge clock) event_clr <= 0;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_off();
    wr2(8'h01);
    repeat (40) @(posedge clock);
    chk("ctl2 off", control_two, 8'h00);
    chk("lines off", {scl, sda}, 2'b11);
    @(posedge clock) mode <= MODE_MASTER;
    en <= 1;
    repeat (10) @(posedge link_clk);
  endtask
  task automatic t_start(input logic ack_st, input logic [7:0] kept);
    wr2(8'h01);
    chk("start req", control_two[0], 1);
    wrb(8'h3c);
    wr2(8'h04);
    chk("write_collision_flag", write_collision_flag, 1);
    chk("buffer kept", transfer_buffer, kept);
    wait_ev();
    chk("ctl2 done", control_two, {1'b0, ack_st, 6'h00});
    chk("start seen", port_status_register[3], 1);
    chk("start lines", {scl, sda}, 2'b10);
    @(posedge clock) write_collision_flag_clr <= 1;
    @(posedge clock) write_collision_flag_clr <= 0;
    #1 chk("write_collision_flag clr", write_collision_flag, 0);
  endtask
  task automatic t_byte(input logic [7:0] b, input logic nack);
    wrb(b);
    chk("buffer", transfer_buffer, b);
    chk("full", port_status_register[0], 1);
    wait_ev();
    chk("byte", rx, b);
    chk("full clr", port_status_register[0], 0);
    chk("ack", control_two[6], nack);
    repeat (100) @(posedge clock);
    chk("scl held", scl, 0);
  endtask
  task automatic t_stop(input logic ack_st);
    wr2(8'h04);
    chk("stop req", control_two[2], 1);
    wait_ev();
    chk("stop ctl2", control_two, {1'b0, ack_st, 6'h00});
    chk("stop lines", {scl, sda}, 2'b11);
    chk("stop status", port_status_register, 8'h00);
  endtask
  task automatic t_coll(input logic [1:0] lines, input logic late);
    @(posedge clock) hold <= late ? 2'b00 : lines;
    wr2(8'h01);
    repeat (8) @(posedge clock);
    hold <= lines;
    repeat (300) @(posedge clock);
    chk("bcol", bus_collision_flag, 1);
    chk("bcol ctl2", control_two, 8'h00);
    chk("bcol event", port_event_flag, 0);
    chk("bcol status", port_status_register, 8'h00);
    @(posedge clock) hold <= 2'b00;
    bcol_clr <= 1;
    @(posedge clock) bcol_clr <= 0;
    #1 chk("bcol clr", bus_collision_flag, 0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1;
    repeat (4) @(posedge clock);
    t_off();
    t_start(0, 8'h00);
    stretch <= 1;
    t_byte(8'ha4, 0);
    stretch <= 0;
    t_byte(8'hcb, 1);
    t_stop(1);
    t_start(1, 8'hcb);
    t_byte(8'ha5, 0);
    t_stop(0);
    chk("high time", 8'(min_hi >= 144.0 && min_hi <= 320.0), 1);
    t_coll(2'b11, 0);
    t_coll(2'b10, 1);
    chk("drive low", {sda_o, scl_o}, 2'b00);
    summarize();
  end
endmodule
